// file: rtl/wdg_pkg.sv
// How it works
// - two watchdog types, time-out or window, select bit, time-out after reset
// - type and period change only in normal mode, frozen in stop mode
// - init: long window after reset release; sleep/restart off, long window on normal
// - service is valid serial write to watchdog control register, acted on at select release
// - a timing write restarts the timer at once with the new setting, unless it lands in a closed window
// - long open window lasts 200 ms and accepts any valid service
// - period settings 1..7 give 10, 20, 50, 100, 200, 500, 1000 ms
// - failure requests restart or fail-safe mode and updates the failure count
// - after watchdog reset release, long open window starts immediately
// - development mode turns the watchdog off, no reset or request
// - each bad service counts up, saturating at 01 (config 2) or 10
// - failure count clears on good service, sleep, stop-disable, non-watchdog fail-safe
// - time-out type: service anytime restarts period; unserved expiry resets
// - window type: closed window is 60 percent, then open window
// - window type: service in closed window or expiry causes watchdog reset
// - data bits 15..8 need even parity, else ignored and serial error set
// - reserved data bit 3 counts in parity though it reads as zero
// - stop disable needs both bits; sequence error clears the second bit
// - service in stop or return to normal re-enables with long window, clears bits
// - first stop-disable bit already set when sequence starts is cleared
// - bus-wake restart enable defaults to 1, changeable only in normal before sequence
// - bus-wake restart raises interrupt, pulls receive low, starts long window
// - watchdog failure holds reset output low for the reset delay time
package wdg_pkg;

  // timing base
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned MS_NS = 1_000_000;
  localparam int unsigned TICK_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned LONG_WIN_MS = 200;
  localparam int unsigned RESET_DELAY_MS_DEF = 10;
  localparam int unsigned CLOSED_PCT = 60;
  localparam logic [10:0] PERIOD_1_MS = 11'h00a;
  localparam logic [10:0] PERIOD_2_MS = 11'h014;
  localparam logic [10:0] PERIOD_3_MS = 11'h032;
  localparam logic [10:0] PERIOD_4_MS = 11'h064;
  localparam logic [10:0] PERIOD_5_MS = 11'h0c8;
  localparam logic [10:0] PERIOD_6_MS = 11'h1f4;
  localparam logic [10:0] PERIOD_7_MS = 11'h3e8;

  // failure count ceilings
  localparam logic [1:0] FAIL_MAX_CFG2 = 2'h1;
  localparam logic [1:0] FAIL_MAX_OTHER = 2'h2;
  localparam logic [1:0] CFG_SEL_TWO = 2'h1;

  // serial frame: data in 15..8, write flag 7, address 6..0
  localparam logic [6:0] SPI_ADDR_WDG_CTRL = 7'h03;
  localparam logic [6:0] SPI_ADDR_WAKE_CTRL1 = 7'h04;
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned CTL_PERIOD_LSB = 0;
  localparam int unsigned CTL_RESERVED_BIT = 3;
  localparam int unsigned CTL_TYPE_BIT = 5;
  localparam int unsigned CTL_STOP2_BIT = 6;
  localparam int unsigned CTL_CHECKSUM_BIT = 7;
  localparam int unsigned WAKE_STOP1_BIT = 0;
  localparam int unsigned WAKE_BUSEN_BIT = 2;
  localparam logic [2:0] PERIOD_RST = 3'h4;

  // bus registers
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CONFIG = 8'h04;
  localparam int unsigned ST_SPIERR_BIT = 9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MODE_INIT = 3'b000,
    MODE_NORMAL = 3'b001,
    MODE_STOP = 3'b010,
    MODE_SLEEP = 3'b011,
    MODE_RESTART = 3'b100,
    MODE_FAILSAFE = 3'b101
  } wdg_mode_t;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_LONGWIN = 3'b001,
    ST_CLOSED = 3'b010,
    ST_OPEN = 3'b011,
    ST_HOLD = 3'b100
  } wdg_state_t;

  function automatic logic [10:0] wdg_period_ms(input logic [2:0] sel);
    logic [10:0] ms;
    case (sel)
      3'h2: ms = PERIOD_2_MS;
      3'h3: ms = PERIOD_3_MS;
      3'h4: ms = PERIOD_4_MS;
      3'h5: ms = PERIOD_5_MS;
      3'h6: ms = PERIOD_6_MS;
      3'h7: ms = PERIOD_7_MS;
      default: ms = PERIOD_1_MS;
    endcase
    return ms;
  endfunction

  function automatic logic [10:0] wdg_closed_ms(input logic [2:0] sel);
    logic [17:0] prod;
    prod = 18'(wdg_period_ms(sel)) * 18'(CLOSED_PCT);
    return 11'(prod / 18'd100);
  endfunction

endpackage

// file: rtl/wdg_supervisor.sv
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module wdg_supervisor #(
  parameter int unsigned TICK_CYCLES = wdg_pkg::TICK_CYCLES_DEF,
  parameter int unsigned RESET_DELAY_MS = wdg_pkg::RESET_DELAY_MS_DEF
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // axi4-lite register slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial command pins
  input wire logic spiSclk,
  input wire logic spiCsN,
  input wire logic spiSdi,
  // chip mode and events
  input wire wdg_pkg::wdg_mode_t sbcMode,
  input wire logic devMode,
  input wire logic busWake,
  // supervisor outputs
  output logic resetOutN,
  output logic restartReq,
  output logic failSafeReq,
  output logic wakeIrq,
  output logic rxdPullLow
);
  import wdg_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES);

  if (TICK_CYCLES < 2) begin : g_chk_tick
    $error("TICK_CYCLES must be at least 2");
  end
  if (RESET_DELAY_MS < 1 || RESET_DELAY_MS > 2047) begin : g_chk_rd
    $error("RESET_DELAY_MS must be 1..2047");
  end

  logic [1:0] sclkSync_q, csnSync_q, sdiSync_q;
  logic sclkPrev_q, csnPrev_q;
  logic [15:0] shift_q;
  logic [4:0] bitCnt_q;
  logic wdgType_q, stop1_q, stop2_q, busWakeEn_q, spiErr_q;
  logic [2:0] period_q;
  logic [1:0] cfgSel_q, failCnt_q;
  logic failSafeOnFail_q, failByWd_q;
  wdg_mode_t modePrev_q;
  wdg_state_t state_q;
  logic [TW-1:0] tickCnt_q;
  logic [10:0] msCnt_q;
  logic awHeld_q, wHeld_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;

  // serial pins cross into clk through two flops each
  always_ff @(posedge clk) begin
    if (rst) begin
      sclkSync_q <= 2'h0;
      csnSync_q <= 2'h3;
      sdiSync_q <= 2'h0;
      sclkPrev_q <= 1'b0;
      csnPrev_q <= 1'b1;
    end else if (ce) begin
      sclkSync_q <= {sclkSync_q[0], spiSclk};
      csnSync_q <= {csnSync_q[0], spiCsN};
      sdiSync_q <= {sdiSync_q[0], spiSdi};
      sclkPrev_q <= sclkSync_q[1];
      csnPrev_q <= csnSync_q[1];
    end
  end

  logic sclkRise, csnRise, csnFall;
  assign sclkRise = sclkSync_q[1] & ~sclkPrev_q & ~csnSync_q[1];
  assign csnRise = csnSync_q[1] & ~csnPrev_q;
  assign csnFall = ~csnSync_q[1] & csnPrev_q;

  // shift register, msb first; frames of other lengths are dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      shift_q <= 16'h0000;
      bitCnt_q <= 5'h00;
    end else if (ce) begin
      if (csnFall) begin
        bitCnt_q <= 5'h00;
      end else if (sclkRise) begin
        shift_q <= {shift_q[14:0], sdiSync_q[1]};
        if (bitCnt_q != 5'h1f) begin
          bitCnt_q <= bitCnt_q + 5'h01;
        end
      end
    end
  end

  // frame decode happens only as select returns high
  logic frameDone, parityOk, modeNormal, modeStop, cmdWdg, cmdWake, service;
  logic [7:0] dataByte;
  assign dataByte = shift_q[15:8];
  assign frameDone = csnRise && bitCnt_q == 5'(FRAME_BITS) && shift_q[7];
  assign parityOk = ~^dataByte; // reserved bit 3 is included as written
  assign modeNormal = sbcMode == MODE_NORMAL;
  assign modeStop = sbcMode == MODE_STOP;
  assign cmdWdg = frameDone && shift_q[6:0] == SPI_ADDR_WDG_CTRL && (modeNormal || modeStop);
  assign cmdWake = frameDone && shift_q[6:0] == SPI_ADDR_WAKE_CTRL1 && modeNormal;
  assign service = cmdWdg && parityOk;

  // watchdog availability
  logic stopOff, wdOff, busRestart, leaveStop;
  assign stopOff = modeStop && stop1_q && stop2_q;
  assign wdOff = devMode || stopOff || sbcMode == MODE_SLEEP
    || sbcMode == MODE_RESTART || sbcMode == MODE_FAILSAFE;
  assign busRestart = busWake && stopOff && busWakeEn_q;
  assign leaveStop = modePrev_q == MODE_STOP && modeNormal;

  // configuration and stop-disable sequence
  always_ff @(posedge clk) begin
    if (rst) begin
      wdgType_q <= 1'b0; // time-out type after defaults
      period_q <= PERIOD_RST;
      stop1_q <= 1'b0;
      stop2_q <= 1'b0;
      busWakeEn_q <= 1'b1;
      modePrev_q <= MODE_INIT;
    end else if (ce) begin
      modePrev_q <= sbcMode;
      if (service && modeNormal) begin
        wdgType_q <= dataByte[CTL_TYPE_BIT]; // normal mode only
        period_q <= dataByte[CTL_PERIOD_LSB +: 3];
        // second bit without the first is a sequence error
        stop2_q <= dataByte[CTL_STOP2_BIT] && stop1_q;
      end
      if (cmdWake) begin
        // a set first bit restarts the sequence by clearing
        stop1_q <= dataByte[WAKE_STOP1_BIT] && !stop1_q;
        if (!stop1_q && !stop2_q) begin
          busWakeEn_q <= dataByte[WAKE_BUSEN_BIT]; // before the sequence only
        end
      end
      // re-enable paths clear both bits
      if ((service && modeStop) || leaveStop || busRestart) begin
        stop1_q <= 1'b0;
        stop2_q <= 1'b0;
      end
    end
  end

  // serial error flag, set beats a software clear in the same cycle
  logic spiErrClr;
  always_ff @(posedge clk) begin
    if (rst) begin
      spiErr_q <= 1'b0;
    end else if (ce) begin
      if (cmdWdg && !parityOk) begin
        spiErr_q <= 1'b1; // command dropped
      end else if (spiErrClr) begin
        spiErr_q <= 1'b0;
      end
    end
  end

  // window timing decisions
  logic tickLast, msDone, effWindow, okEv, failEv;
  logic [10:0] limitMs;
  assign tickLast = tickCnt_q == TW'(TICK_CYCLES - 1);
  assign effWindow = (service && modeNormal) ? dataByte[CTL_TYPE_BIT] : wdgType_q;
  always_comb begin
    limitMs = 11'(RESET_DELAY_MS);
    unique case (state_q)
      ST_LONGWIN: limitMs = 11'(LONG_WIN_MS);
      ST_CLOSED: limitMs = wdg_closed_ms(period_q);
      ST_OPEN: limitMs = wdgType_q ? wdg_period_ms(period_q) - wdg_closed_ms(period_q)
        : wdg_period_ms(period_q);
      ST_HOLD: limitMs = 11'(RESET_DELAY_MS);
      ST_OFF: limitMs = 11'(RESET_DELAY_MS);
    endcase
  end
  assign msDone = tickLast && msCnt_q + 11'h001 >= limitMs;
  assign okEv = service && !wdOff && (state_q == ST_LONGWIN || state_q == ST_OPEN
    || (state_q == ST_CLOSED && !wdgType_q));
  assign failEv = !wdOff && ((service && state_q == ST_CLOSED && wdgType_q)
    || (msDone && (state_q == ST_LONGWIN || state_q == ST_OPEN)));

  // watchdog state, ms timer and reset output
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_HOLD; // reset output held low first, then long window
      tickCnt_q <= '0;
      msCnt_q <= 11'h000;
      resetOutN <= 1'b0;
      restartReq <= 1'b0;
      failSafeReq <= 1'b0;
    end else if (ce) begin
      restartReq <= 1'b0;
      failSafeReq <= 1'b0;
      tickCnt_q <= tickLast ? '0 : tickCnt_q + TW'(1);
      if (tickLast) begin
        msCnt_q <= msCnt_q + 11'h001;
      end
      if (state_q == ST_HOLD) begin
        if (msDone) begin
          resetOutN <= 1'b1;
          state_q <= ST_LONGWIN;
          tickCnt_q <= '0;
          msCnt_q <= 11'h000;
        end
      end else if (wdOff) begin
        state_q <= ST_OFF;
      end else if (state_q == ST_OFF || busRestart) begin
        state_q <= ST_LONGWIN; // back on after sleep, restart or stop
        tickCnt_q <= '0;
        msCnt_q <= 11'h000;
      end else if (failEv) begin
        state_q <= ST_HOLD;
        resetOutN <= 1'b0;
        restartReq <= !failSafeOnFail_q;
        failSafeReq <= failSafeOnFail_q;
        tickCnt_q <= '0;
        msCnt_q <= 11'h000;
      end else if (okEv || (service && modeNormal)) begin
        // new timing also restarts the timer at once
        state_q <= effWindow ? ST_CLOSED : ST_OPEN;
        tickCnt_q <= '0;
        msCnt_q <= 11'h000;
      end else if (state_q == ST_CLOSED && msDone) begin
        state_q <= ST_OPEN;
        tickCnt_q <= '0;
        msCnt_q <= 11'h000;
      end
    end
  end

  // failure counter with configuration-dependent ceiling
  logic [1:0] failMax;
  logic failClear;
  assign failMax = cfgSel_q == CFG_SEL_TWO ? FAIL_MAX_CFG2 : FAIL_MAX_OTHER;
  assign failClear = state_q == ST_OFF && (stopOff || sbcMode == MODE_SLEEP
    || (sbcMode == MODE_FAILSAFE && !failByWd_q));
  always_ff @(posedge clk) begin
    if (rst) begin
      failCnt_q <= 2'h0;
      failByWd_q <= 1'b0;
    end else if (ce) begin
      if (failEv) begin
        failByWd_q <= 1'b1;
        if (failCnt_q < failMax) begin
          failCnt_q <= failCnt_q + 2'h1;
        end
      end else if (okEv || failClear) begin
        failCnt_q <= 2'h0;
        failByWd_q <= 1'b0;
      end
    end
  end

  // bus wake notification, receive pull held until next good service
  always_ff @(posedge clk) begin
    if (rst) begin
      wakeIrq <= 1'b0;
      rxdPullLow <= 1'b0;
    end else if (ce) begin
      wakeIrq <= busRestart;
      if (busRestart) begin
        rxdPullLow <= 1'b1;
      end else if (okEv) begin
        rxdPullLow <= 1'b0;
      end
    end
  end

  // axi write path: address and data taken in either order
  logic doWrite, wrStatus, wrConfig;
  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
  assign wrStatus = awAddr_q[7:2] == REG_STATUS[7:2];
  assign wrConfig = awAddr_q[7:2] == REG_CONFIG[7:2];
  assign spiErrClr = doWrite && wrStatus && wStrb_q[1] && wData_q[ST_SPIERR_BIT];
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
    end else if (ce) begin
      if (s_axi_awready && s_axi_awvalid) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!awHeld_q && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!wHeld_q && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wrStatus || wrConfig) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // config register: failure configuration and reaction select
  always_ff @(posedge clk) begin
    if (rst) begin
      cfgSel_q <= 2'h0;
      failSafeOnFail_q <= 1'b0;
    end else if (ce && doWrite && wrConfig && wStrb_q[0]) begin
      cfgSel_q <= wData_q[1:0];
      failSafeOnFail_q <= wData_q[2];
    end
  end

  // axi read path, one read at a time
  logic [31:0] rdMux;
  logic rdHit;
  always_comb begin
    rdMux = 32'h0000_0000;
    rdHit = 1'b1;
    if (s_axi_araddr[7:2] == REG_STATUS[7:2]) begin
      rdMux = {18'h00000, resetOutN, state_q, spiErr_q, busWakeEn_q, stop2_q, stop1_q,
        period_q, wdgType_q, failCnt_q};
    end else if (s_axi_araddr[7:2] == REG_CONFIG[7:2]) begin
      rdMux = {29'h00000000, failSafeOnFail_q, cfgSel_q};
    end else begin
      rdHit = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // wdg_supervisor

// file: tb/wdg_supervisor_asserts.sv
`timescale 1ns/1ps
module wdg_supervisor_asserts #(
  parameter int unsigned TICK_CYCLES = 4,
  parameter int unsigned RESET_DELAY_MS = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // supervisor side
  input wire logic devMode,
  input wire logic resetOutN,
  input wire logic restartReq,
  input wire logic failSafeReq,
  input wire logic wakeIrq,
  input wire logic rxdPullLow
);
  localparam int unsigned RD = RESET_DELAY_MS * TICK_CYCLES;
  logic [15:0] lowCnt_q;

  // length of the current low stretch of the reset output
  always_ff @(posedge clk) begin
    if (rst || resetOutN) begin
      lowCnt_q <= 16'h0000;
    end else begin
      lowCnt_q <= lowCnt_q + 16'h0001;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // bus transfers taken by the slave
  sequence rdTake;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wrTake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  chk_read_answer: assert property (rdTake |=> s_axi_rvalid)
    else $error("read answer missing");
  chk_write_answer: assert property (wrTake |-> ##2 s_axi_bvalid)
    else $error("write answer missing");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_hold_length: assert property ($rose(resetOutN) |->
    lowCnt_q >= RD - 1 && lowCnt_q <= RD + 2) else $error("reset hold length off");
  chk_fail_request: assert property ($fell(resetOutN) |->
    restartReq || failSafeReq) else $error("failure without mode request");
  chk_req_cause: assert property (restartReq || failSafeReq |->
    !resetOutN && !(restartReq && failSafeReq)) else $error("bad mode request");
  chk_req_pulse: assert property (restartReq || failSafeReq |=>
    !restartReq && !failSafeReq) else $error("mode request too long");
  chk_dev_quiet: assert property (devMode && $past(devMode) |->
    !restartReq && !failSafeReq) else $error("request in development mode");
  chk_wake_rxd: assert property (wakeIrq |-> rxdPullLow)
    else $error("wake without receive pull");
endmodule // wdg_supervisor_asserts

bind wdg_supervisor wdg_supervisor_asserts #(
  .TICK_CYCLES(TICK_CYCLES),
  .RESET_DELAY_MS(RESET_DELAY_MS)
) chk (.*);

// file: tb/wdg_spi_host.sv
`timescale 1ns/1ps
module wdg_spi_host (
  // serial pins
  output logic sclk,
  output logic csN,
  output logic sdi
);
  // clock idles low, select idles high
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    sdi = 1'b0;
  end

  // one write frame, msb first; data set while the clock is low
  task automatic send(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] f;
    f = {d, 1'b1, a}; // write flag set
    #7 csN = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi = f[i];
      #100 sclk = 1'b1;
      #100 sclk = 1'b0;
    end
    #100 csN = 1'b1;
    sdi = ~sdi; // released line must not keep the last bit
    #100;
  endtask

  // top data bit makes the byte even
  function automatic logic [7:0] par(input logic [7:0] d);
    return {^d[6:0], d[6:0]};
  endfunction
endmodule // wdg_spi_host

// file: tb/wdg_supervisor_tb.sv
`timescale 1ns/1ps
module wdg_supervisor_tb;
  import wdg_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic spiSclk, spiCsN, spiSdi;
  wdg_mode_t sbcMode;
  logic devMode, busWake;
  logic resetOutN, restartReq, failSafeReq, wakeIrq, rxdPullLow;
  int n_fail = 0, checks = 0, cyc = 0;

  always #12.5 clk = ~clk;

  // short time base keeps the run brief
  wdg_supervisor #(.TICK_CYCLES(4), .RESET_DELAY_MS(2)) uut (.*);
  wdg_spi_host host (.sclk(spiSclk), .csN(spiCsN), .sdi(spiSdi));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
    chk(32'(n < 50), 32'h1); // write answered before the limit
    chk(32'(s_axi_bresp), 32'(er));
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
    chk(32'(n < 50), 32'h1); // read answered before the limit
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask

  // masked status compare
  task automatic st(input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axr(REG_STATUS, d, r);
    chk(d & m, e);
  endtask

  task automatic spi(input logic [6:0] a, input logic [7:0] d);
    host.send(a, d);
    @(posedge clk);
  endtask

  // bounded wait for a reset output level
  task automatic wlvl(input logic lv, output int n);
    n = 0;
    while (resetOutN !== lv && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  task automatic t_reset();
    int n, t0;
    logic [31:0] d;
    logic [1:0] r;
    wlvl(1'b1, n);
    t0 = cyc;
    st(32'h3fff, 32'h2520); // long window, time-out, period 4
    axr(8'h08, d, r);
    chk({d[29:0], r}, 32'h2); // unmapped read gives zero and error
    wlvl(1'b0, n);
    chk(32'(cyc - t0 >= 795 && cyc - t0 <= 803), 32'h1); // long window
    chk(32'(restartReq), 32'h1); // restart asked
    sbcMode <= MODE_NORMAL;
    wlvl(1'b1, n);
    st(32'h1c03, 32'h0401); // count 1, long window again
    $display("reset test done");
  endtask

  task automatic t_timeout();
    int n, t0;
    axw(REG_CONFIG, 32'h5, RESP_OKAY); // config 2, fail-safe on failure
    spi(SPI_ADDR_WDG_CTRL, host.par(8'h07));
    st(32'h1c3f, 32'h0c38); // open, period 7, count cleared
    repeat (2000) @(posedge clk);
    spi(SPI_ADDR_WDG_CTRL, host.par(8'h07));
    t0 = cyc;
    wlvl(1'b0, n);
    chk(32'(cyc - t0 >= 3990 && cyc - t0 <= 4004), 32'h1); // fresh period
    chk(32'(failSafeReq), 32'h1); // fail-safe asked
    wlvl(1'b1, n);
    spi(SPI_ADDR_WDG_CTRL, host.par(8'h01));
    t0 = cyc;
    wlvl(1'b0, n);
    chk(32'(cyc - t0 >= 34 && cyc - t0 <= 42), 32'h1); // shortest period
    wlvl(1'b1, n);
    wlvl(1'b0, n);
    st(32'h3, 32'h1); // count stays at 01
    axw(REG_CONFIG, 32'h0, RESP_OKAY);
    wlvl(1'b1, n);
    $display("timeout test done");
  endtask

  task automatic t_window();
    int n;
    spi(SPI_ADDR_WDG_CTRL, host.par(8'h24));
    st(32'h1c07, 32'h0804); // window type starts closed
    repeat (150) @(posedge clk);
    spi(SPI_ADDR_WDG_CTRL, host.par(8'h24)); // lands near 0.73 of the period
    st(32'h1c03, 32'h0800); // accepted, closed again
    repeat (225) @(posedge clk);
    st(32'h1c00, 32'h0800); // still closed below 60 percent
    repeat (25) @(posedge clk);
    st(32'h1c00, 32'h0c00); // open past 60 percent
    wlvl(1'b0, n);
    chk(32'(restartReq), 32'h1); // unserved period
    wlvl(1'b1, n);
    spi(SPI_ADDR_WDG_CTRL, host.par(8'h24));
    spi(SPI_ADDR_WDG_CTRL, host.par(8'h24));
    wlvl(1'b0, n);
    chk(32'(n), 32'h0); // reset already low as the frame ends
    st(32'h3c03, 32'h1001); // reset hold, one failure counted
    wlvl(1'b1, n);
    sbcMode <= MODE_SLEEP;
    repeat (2) @(posedge clk);
    st(32'h1c03, 32'h0); // off in sleep, count cleared
    sbcMode <= MODE_NORMAL;
    $display("window test done");
  endtask

  task automatic t_parity();
    spi(SPI_ADDR_WDG_CTRL, 8'h01);
    st(32'h23c, 32'h224); // odd byte ignored, error flag
    axw(REG_STATUS, 32'h200, RESP_OKAY);
    st(32'h200, 32'h0);
    spi(SPI_ADDR_WDG_CTRL, 8'h08);
    st(32'h23c, 32'h224); // reserved bit makes it odd
    axw(REG_STATUS, 32'h200, RESP_OKAY);
    spi(SPI_ADDR_WDG_CTRL, host.par(8'h0f));
    st(32'h23c, 32'h038); // reserved bit balanced, accepted
    axw(8'h10, 32'h0, RESP_SLVERR);
    $display("parity test done");
  endtask

  task automatic t_dev();
    int n;
    devMode <= 1'b1;
    wlvl(1'b0, n);
    chk(32'(n), 32'd5000); // no reset while off
    st(32'h1c00, 32'h0); // off
    devMode <= 1'b0;
    @(posedge clk);
    st(32'h1c00, 32'h0400); // restarts with long window
    $display("dev test done");
  endtask

  task automatic t_stop();
    int n;
    spi(SPI_ADDR_WDG_CTRL, host.par(8'h47));
    st(32'h0c0, 32'h0); // second bit alone is refused
    spi(SPI_ADDR_WAKE_CTRL1, 8'h05); // first bit goes first
    spi(SPI_ADDR_WAKE_CTRL1, 8'h05);
    st(32'h0c0, 32'h0); // set again while set clears it
    spi(SPI_ADDR_WAKE_CTRL1, 8'h05);
    spi(SPI_ADDR_WDG_CTRL, host.par(8'h47));
    st(32'h1c0, 32'h1c0); // both bits, wake restart on
    sbcMode <= MODE_STOP;
    repeat (3) @(posedge clk);
    st(32'h1c03, 32'h0); // off in stop, count clear
    busWake <= 1'b1;
    @(posedge clk);
    busWake <= 1'b0;
    #1;
    n = 0;
    while (wakeIrq !== 1'b1 && n < 10) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(32'({wakeIrq, rxdPullLow}), 32'h3); // interrupt and receive pull
    @(posedge clk);
    st(32'h1cc0, 32'h0400); // long window, bits cleared
    spi(SPI_ADDR_WDG_CTRL, host.par(8'h01));
    st(32'h3c, 32'h38); // settings frozen in stop
    chk(32'(rxdPullLow), 32'h0); // released by a good service
    sbcMode <= MODE_NORMAL;
    $display("stop test done");
  endtask

  initial begin
    s_axi_awaddr <= 8'h00;
    s_axi_araddr <= 8'h00;
    s_axi_wdata <= 32'h0000_0000;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    sbcMode <= MODE_INIT;
    devMode <= 1'b0;
    busWake <= 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_timeout();
    t_window();
    t_parity();
    t_dev();
    t_stop();
    final_report();
  end
endmodule // wdg_supervisor_tb
